// ### include/led_driver_pkg.sv
package led_driver_pkg;

    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned NUM_STRINGS     = 6;
    localparam int unsigned LEVEL_W         = 8;
    localparam int unsigned CNT_W           = 22;
    localparam int unsigned DUTY_W          = 9;
    localparam int unsigned AMP_W           = 8;
    localparam int unsigned DUTY_SHIFT      = 8;
    localparam int unsigned NUM_W           = CNT_W + DUTY_SHIFT;

    // supply lockout comparator levels, for reference by the analog side
    localparam int unsigned LOCKOUT_RISE_MV = 4250;
    localparam int unsigned LOCKOUT_HYST_MV = 20;

    localparam int unsigned SCAN_TIME_US    = 4200;
    localparam int unsigned SCAN_CYCLES     = SCAN_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FAULT_TIME_NS   = 65_000_000;
    localparam int unsigned FAULT_LOW_NS    = 8_125_000;
    localparam int unsigned FAULT_CYCLES    = (FAULT_TIME_NS / 1000)
                                              * (CLK_HZ / 1_000_000);
    localparam int unsigned LOW_RATIO       = FAULT_TIME_NS / FAULT_LOW_NS;

    localparam int unsigned SW_LOW_KHZ      = 500;
    localparam int unsigned SW_MID_KHZ      = 750;
    localparam int unsigned SW_HIGH_KHZ     = 1000;
    localparam logic [7:0]  OSC_DIV_LOW     = 8'(CLK_HZ / (SW_LOW_KHZ * 1000));
    localparam logic [7:0]  OSC_DIV_MID     = 8'(CLK_HZ / (SW_MID_KHZ * 1000));
    localparam logic [7:0]  OSC_DIV_HIGH    = 8'(CLK_HZ / (SW_HIGH_KHZ * 1000));

    localparam logic [DUTY_W-1:0] DUTY_FULL = 9'h100;
    localparam logic [DUTY_W-1:0] DUTY_KNEE = 9'h020;
    localparam logic [AMP_W-1:0]  AMP_FULL  = 8'hff;
    localparam logic [AMP_W-1:0]  AMP_KNEE  = 8'h20;
    // floor of the pulse window, in 1/256 of the period (about 1 % average)
    localparam logic [4:0]        FLOOR_NUM = 5'h15;
    localparam logic [31:0]       LOCK_NUM  = 32'h0000_0006;
    localparam logic [31:0]       LOCK_DEN  = 32'h0000_000a;

    localparam int unsigned SY_PD      = 0;
    localparam int unsigned SY_UV_RISE = 1;
    localparam int unsigned SY_UV_FALL = 2;
    localparam int unsigned SY_FSEL_LO = 3;
    localparam int unsigned SY_FSEL_HI = 4;
    localparam int unsigned SY_OVS     = 5;
    localparam int unsigned SY_PWM     = 6;
    localparam int unsigned SY_MODE    = 7;
    localparam int unsigned SY_CONV    = 8;
    localparam int unsigned SY_GND     = 9;
    localparam int unsigned SY_HOT     = SY_GND + NUM_STRINGS;
    localparam int unsigned SYNC_W     = SY_HOT + NUM_STRINGS;

    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_SCAN  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_FAULT = 4'b1000
    } ctrl_state_type;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
    endfunction : sat_inc

endpackage : led_driver_pkg

// ### include/duty_div_if.sv
`timescale 1ns/10ps
interface duty_div_if;
    import led_driver_pkg::*;
    logic                start;
    logic [CNT_W-1:0]    high_time;
    logic [CNT_W-1:0]    period;
    logic                done;
    logic [DUTY_W-1:0]   duty;

    modport requester (output start, output high_time, output period,
                       input done, input duty);
    modport divider   (input start, input high_time, input period,
                       output done, output duty);
endinterface : duty_div_if

// ### rtl/duty_divider.sv
`timescale 1ns/10ps
module duty_divider
    import led_driver_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    duty_div_if.divider      div
);
    typedef struct packed {
        logic                busy;
        logic [4:0]          count;
        logic [CNT_W:0]      rem;
        logic [NUM_W-1:0]    num;
        logic [CNT_W-1:0]    den;
        logic [DUTY_W-1:0]   quot;
        logic                done;
    } div_reg_type;

    div_reg_type r;
    div_reg_type next_r;
    logic [CNT_W:0] shifted;

    // shift-subtract, one quotient bit a cycle; high time never exceeds
    // the period, so the quotient fits in the duty width
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        shifted = {r.rem[CNT_W-1:0], r.num[NUM_W-1]};
        if (!r.busy) begin
            if (div.start) begin
                next_r.busy  = 1'b1;
                next_r.count = 5'(NUM_W);
                next_r.rem   = '0;
                next_r.num   = {div.high_time, 8'h00};
                next_r.den   = div.period;
                next_r.quot  = '0;
            end
        end else begin
            next_r.num = {r.num[NUM_W-2:0], 1'b0};
            if (shifted >= {1'b0, r.den}) begin
                next_r.rem  = shifted - {1'b0, r.den};
                next_r.quot = {r.quot[DUTY_W-2:0], 1'b1};
            end else begin
                next_r.rem  = shifted;
                next_r.quot = {r.quot[DUTY_W-2:0], 1'b0};
            end
            next_r.count = r.count - 5'h01;
            if (r.count == 5'h01) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign div.done = r.done;
    assign div.duty = r.quot;
endmodule : duty_divider

// ### rtl/level_extremes.sv
`timescale 1ns/10ps
module level_extremes
    import led_driver_pkg::*;
(
    input  wire logic [NUM_STRINGS-1:0][LEVEL_W-1:0] i_levels,
    input  wire logic [NUM_STRINGS-1:0]              i_mask,
    input  wire logic                                i_clk,
    input  wire logic                                i_rst,
    output logic      [LEVEL_W-1:0]                  o_highest,
    output logic      [LEVEL_W-1:0]                  o_lowest
);
    typedef struct packed {
        logic [LEVEL_W-1:0] hi;
        logic [LEVEL_W-1:0] lo;
    } ext_reg_type;

    ext_reg_type r;
    ext_reg_type next_r;

    always_comb begin
        next_r.hi = '0;
        next_r.lo = '1;
        for (int i = 0; i < NUM_STRINGS; i++) begin
            if (i_mask[i]) begin
                if (i_levels[i] > next_r.hi) begin
                    next_r.hi = i_levels[i];
                end
                if (i_levels[i] < next_r.lo) begin
                    next_r.lo = i_levels[i];
                end
            end
        end
        // with no string in use the regulation loop sees zero
        if (i_mask == '0) begin
            next_r.lo = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_highest = r.hi;
    assign o_lowest  = r.lo;
endmodule : level_extremes

// ### rtl/led_string_driver_control.sv
// Function
// RULE1: controller stays off until supply rises past lockout, with hysteresis.
// RULE2: at startup, strings whose feedback pin is grounded are disabled.
// RULE3: boost may not switch until the feedback pin scan has finished.
// RULE4: power-down input low turns off regulator, reference, sources, logic.
// RULE5: select input picks 500, 750 or 1000 kHz boost frequency.
// RULE6: overvoltage sense turns boost switch off until it falls back.
// RULE7: each string source switches on or off well inside ten microseconds.
// RULE8: the enabled string set is frozen after power-up.
// RULE9: highest and lowest enabled feedback levels; lowest drives regulation.
// RULE10: highest level over limit longer than timeout sets fault latch.
// RULE11: fault latch leaves the internal regulator running.
// RULE12: direct pulse mode timeout is base time over brightness duty.
// RULE13: analog timeout fixed above knee, shorter constant over duty below.
// RULE14: fault latch clears only by power cycle or power-down toggle.
// RULE15: analog mode scales DC amplitude above knee, pulses below it.
// RULE16: analog loop tracks brightness period and updates in step with it.
// RULE17: direct pulse mode follows brightness input at full-scale amplitude.
// RULE18: mode pin high selects analog dimming, low selects direct pulse.
// RULE19: every pulsed current turn-on is aligned to the brightness input.
// RULE20: string current only during converter on-time, off during off-time.
// RULE21: loop locks only between 0.6 of free-run frequency and free-run.
// RULE22: both modes reach a hundred-to-one average current range.
// RULE23: host keeps brightness high time at least fifty microseconds.
// RULE24: with mode pin low the loop keeps running but dimming ignores it.
// RULE25: duty is measured as high time over period, used everywhere.
// RULE26: fault timer restarts when the highest level drops below limit.
`timescale 1ns/10ps
module led_string_driver_control
    import led_driver_pkg::*;
#(
    parameter int unsigned SCAN_CYCLES_P  = SCAN_CYCLES,
    parameter int unsigned FAULT_CYCLES_P = FAULT_CYCLES
) (
    input  wire logic                                i_clk,
    input  wire logic                                i_rst,
    input  wire logic                                i_power_down_input_n,
    input  wire logic                                i_vcc_above_rise,
    input  wire logic                                i_vcc_above_fall,
    input  wire logic                                i_freq_sel_above_low,
    input  wire logic                                i_freq_sel_above_high,
    input  wire logic                                i_output_overvoltage_sense,
    input  wire logic                                i_brightness_pwm_input,
    input  wire logic                                i_dimming_mode_select,
    input  wire logic                                i_converter_on_time,
    input  wire logic [NUM_STRINGS-1:0]              i_string_feedback_grounded,
    input  wire logic [NUM_STRINGS-1:0]              i_string_feedback_over,
    input  wire logic [NUM_STRINGS-1:0][LEVEL_W-1:0] i_string_feedback_level,
    input  wire logic [CNT_W-1:0]                    i_loop_free_run_period,
    output logic                                     o_regulator_enable,
    output logic                                     o_reference_enable,
    output logic                                     o_controller_enable,
    output logic                                     o_scan_done,
    output logic [NUM_STRINGS-1:0]                   o_string_mask,
    output logic [NUM_STRINGS-1:0]                   o_string_enable,
    output logic [AMP_W-1:0]                         o_current_amplitude,
    output logic                                     o_boost_switch_enable,
    output logic                                     o_boost_clock_tick,
    output logic [LEVEL_W-1:0]                       o_highest_string_level,
    output logic [LEVEL_W-1:0]                       o_lowest_string_level,
    output logic [DUTY_W-1:0]                        o_brightness_duty,
    output logic                                     o_fault_latched,
    output logic                                     o_loop_locked
);
    localparam logic [31:0] SCAN_LAST   = 32'(SCAN_CYCLES_P - 1);
    localparam logic [31:0] FAULT_LIMIT = 32'(64'(FAULT_CYCLES_P)
                                              * 64'(DUTY_FULL));

    typedef struct packed {
        logic [SYNC_W-1:0]       meta;
        logic [SYNC_W-1:0]       sync;
        logic                    pwm_prev;
        logic                    supply_ok;
        ctrl_state_type          state;
        logic                    fault;
        logic [31:0]             scan_cnt;
        logic [31:0]             fault_acc;
        logic [NUM_STRINGS-1:0]  mask;
        logic [7:0]              osc_cnt;
        logic                    osc_tick;
        logic [CNT_W-1:0]        period_cnt;
        logic [CNT_W-1:0]        high_cnt;
        logic [CNT_W-1:0]        pulse_cnt;
        logic [CNT_W-1:0]        period;
        logic [CNT_W-1:0]        cap_high;
        logic [CNT_W+2:0]        on_len;
        logic                    div_start;
        logic [DUTY_W-1:0]       duty;
        logic                    locked;
        logic [AMP_W-1:0]        analog_amp;
        logic [AMP_W-1:0]        amp;
        logic [NUM_STRINGS-1:0]  strings;
        logic                    boost_en;
    } ctrl_reg_type;

    ctrl_reg_type r;
    ctrl_reg_type next_r;

    logic [SYNC_W-1:0]       raw;
    logic                    pd_n;
    logic                    pwm;
    logic                    analog;
    logic                    running;
    logic                    over;
    logic                    pwm_rise;
    logic                    pulse_on;
    logic [7:0]              osc_div;
    logic [11:0]             weight;
    logic [CNT_W+4:0]        floor_prod;
    logic [CNT_W+2:0]        floor_len;
    logic [CNT_W+2:0]        stretch_len;

    duty_div_if div_bus ();

    duty_divider u_div (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .div   (div_bus)
    );

    level_extremes u_ext (
        .i_levels  (i_string_feedback_level),
        .i_mask    (r.mask),
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .o_highest (o_highest_string_level),
        .o_lowest  (o_lowest_string_level)              // [RULE9]
    );

    assign div_bus.start     = r.div_start;
    assign div_bus.high_time = r.cap_high;
    assign div_bus.period    = r.period;

    assign raw = {i_string_feedback_over, i_string_feedback_grounded,
                  i_converter_on_time, i_dimming_mode_select,
                  i_brightness_pwm_input, i_output_overvoltage_sense,
                  i_freq_sel_above_high, i_freq_sel_above_low,
                  i_vcc_above_fall, i_vcc_above_rise, i_power_down_input_n};

    // everything but the synchronisers and lockout state goes idle
    function automatic ctrl_reg_type idle(input ctrl_reg_type cur);
        ctrl_reg_type v;
        v            = '0;
        v.meta       = cur.meta;
        v.sync       = cur.sync;
        v.pwm_prev   = cur.pwm_prev;
        v.supply_ok  = cur.supply_ok;
        v.state      = ST_OFF;
        v.analog_amp = AMP_FULL;
        v.amp        = AMP_FULL;
        return v;
    endfunction : idle

    always_comb begin
        pd_n     = r.sync[SY_PD];
        pwm      = r.sync[SY_PWM];
        analog   = r.sync[SY_MODE];                      // [RULE18]
        running  = (r.state == ST_RUN);
        over     = |(r.sync[SY_HOT +: NUM_STRINGS] & r.mask);
        pwm_rise = pwm & ~r.pwm_prev;
        pulse_on = (r.duty >= DUTY_KNEE)
                   || ({3'b000, r.pulse_cnt} < r.on_len);   // [RULE15]
        floor_prod  = r.period * FLOOR_NUM;
        floor_len   = {6'b000000, floor_prod[CNT_W+4:8]};
        stretch_len = {r.cap_high, 3'b000};
        if (r.sync[SY_FSEL_HI]) begin                      // [RULE5]
            osc_div = OSC_DIV_HIGH;
        end else if (r.sync[SY_FSEL_LO]) begin
            osc_div = OSC_DIV_MID;
        end else begin
            osc_div = OSC_DIV_LOW;
        end
        if (!analog) begin
            weight = {3'b000, r.duty};                     // [RULE12]
        end else if (r.duty >= DUTY_KNEE) begin
            weight = {3'b000, DUTY_FULL};                  // [RULE13]
        end else begin
            weight = 12'(r.duty * LOW_RATIO);              // [RULE13]
        end

        next_r           = r;
        next_r.meta      = raw;
        next_r.sync      = r.meta;
        next_r.pwm_prev  = pwm;
        next_r.div_start = 1'b0;
        next_r.osc_tick  = 1'b0;

        if (r.sync[SY_UV_RISE]) begin                      // [RULE1]
            next_r.supply_ok = 1'b1;
        end else if (!r.sync[SY_UV_FALL]) begin
            next_r.supply_ok = 1'b0;
        end

        case (r.state)
            ST_OFF: begin
                if (r.supply_ok) begin                     // [RULE1]
                    next_r.state    = ST_SCAN;
                    next_r.scan_cnt = '0;
                end
            end
            ST_SCAN: begin
                next_r.scan_cnt = r.scan_cnt + 32'h0000_0001;
                if (r.scan_cnt >= SCAN_LAST) begin         // [RULE3]
                    next_r.mask  = ~r.sync[SY_GND +: NUM_STRINGS]; // [RULE2]
                    next_r.state = ST_RUN;
                end
            end
            ST_RUN: begin
                // mask is only loaded in the scan state and cleared by idle
                if (r.fault_acc >= FAULT_LIMIT) begin      // [RULE10] [RULE8]
                    next_r.fault = 1'b1;
                    next_r.state = ST_FAULT;
                end
            end
            ST_FAULT: begin
                next_r.state = ST_FAULT;                   // [RULE14]
            end
            default: begin
                next_r.state = ST_OFF;
            end
        endcase

        // duty-weighted accumulation stretches the base time by 1/duty in direct pulse mode
        if (running && over) begin                         // [RULE10]
            next_r.fault_acc = r.fault_acc + {20'h00000, weight};
        end else begin
            next_r.fault_acc = '0;                         // [RULE26]
        end

        if (r.osc_cnt >= osc_div - 8'h01) begin
            next_r.osc_cnt  = '0;
            next_r.osc_tick = running;                     // [RULE3]
        end else begin
            next_r.osc_cnt = r.osc_cnt + 8'h01;
        end

        // period and high time, in the same counters for both modes
        if (pwm_rise) begin                                // [RULE25]
            next_r.period     = r.period_cnt;
            next_r.cap_high   = r.high_cnt;
            next_r.period_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
            next_r.high_cnt   = {{(CNT_W-1){1'b0}}, 1'b1};
            next_r.pulse_cnt  = '0;                        // [RULE19]
            next_r.div_start  = (r.period_cnt != {CNT_W{1'b1}});
            next_r.locked = ({10'h000, r.period_cnt}
                             >= {10'h000, i_loop_free_run_period})
                && ({10'h000, r.period_cnt} * LOCK_NUM
                    <= {10'h000, i_loop_free_run_period} * LOCK_DEN); // [RULE21]
        end else begin
            next_r.period_cnt = sat_inc(r.period_cnt);
            next_r.pulse_cnt  = sat_inc(r.pulse_cnt);
            if (pwm) begin
                next_r.high_cnt = sat_inc(r.high_cnt);
            end
        end
        // input stuck at one level: no period left to measure
        if (r.period_cnt == {CNT_W{1'b1}}) begin
            next_r.duty   = pwm ? DUTY_FULL : '0;
            next_r.locked = 1'b0;
        end

        // the loop runs in both modes; only analog mode dims with its result
        if (div_bus.done) begin                            // [RULE24]
            next_r.duty = div_bus.duty;                    // [RULE25]
            if (analog && r.locked) begin                  // [RULE16]
                if (div_bus.duty >= DUTY_KNEE) begin       // [RULE15]
                    next_r.analog_amp = (div_bus.duty[DUTY_W-1])
                                        ? AMP_FULL
                                        : div_bus.duty[AMP_W-1:0];
                end else begin
                    next_r.analog_amp = AMP_KNEE;
                end
                // below the knee the window never shrinks past the floor
                next_r.on_len = (stretch_len > floor_len)
                                ? stretch_len : floor_len; // [RULE22]
            end
        end

        next_r.amp = analog ? r.analog_amp : AMP_FULL;     // [RULE17]
        if (running && r.sync[SY_CONV]) begin              // [RULE20]
            if (analog) begin
                next_r.strings = r.mask & {NUM_STRINGS{pulse_on}};
            end else begin
                next_r.strings = r.mask & {NUM_STRINGS{pwm}}; // [RULE17]
            end
        end else begin
            next_r.strings = '0;                           // [RULE7]
        end
        next_r.boost_en = running && !r.sync[SY_OVS]
                          && (analog || pwm);              // [RULE6] [RULE17]

        // power-down or lockout idles all control logic and the latch
        if (!pd_n || !r.supply_ok) begin                   // [RULE4] [RULE14]
            next_r = idle(next_r);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= idle('0);
        end else begin
            r <= next_r;
        end
    end

    // the regulator follows only the power-down pin, never the fault
    assign o_regulator_enable    = pd_n;                   // [RULE11] [RULE4]
    assign o_reference_enable    = pd_n;                   // [RULE4]
    assign o_controller_enable   = running;
    assign o_scan_done           = running || (r.state == ST_FAULT);
    assign o_string_mask         = r.mask;
    assign o_string_enable       = r.strings;
    assign o_current_amplitude   = r.amp;
    assign o_boost_switch_enable = r.boost_en;
    assign o_boost_clock_tick    = r.osc_tick;
    assign o_brightness_duty     = r.duty;
    assign o_fault_latched       = r.fault;
    assign o_loop_locked         = r.locked;
endmodule : led_string_driver_control

// ### tb/host_brightness_model.sv
`timescale 1ns/10ps
module host_brightness_model (
    input  wire logic i_clk,
    output logic      o_pwm
);
    localparam int PERIOD = 12500;
    localparam int HIGH   = 6400;
    int cnt = 0;
    // high time held at 51.2 us, above the shortest the device accepts
    always @(posedge i_clk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        o_pwm <= (cnt < HIGH);
    end
endmodule : host_brightness_model

// ### tb/led_ctl_assertions.sv
`timescale 1ns/10ps
module led_ctl_assertions
    import led_driver_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_power_down_input_n,
    input  wire logic                   i_output_overvoltage_sense,
    input  wire logic                   i_converter_on_time,
    input  wire logic                   o_regulator_enable,
    input  wire logic                   o_controller_enable,
    input  wire logic                   o_scan_done,
    input  wire logic [NUM_STRINGS-1:0] o_string_mask,
    input  wire logic [NUM_STRINGS-1:0] o_string_enable,
    input  wire logic                   o_boost_switch_enable,
    input  wire logic                   o_boost_clock_tick,
    input  wire logic                   o_fault_latched
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_pd_all_off:
        assert property (!i_power_down_input_n [*4] |=> !o_regulator_enable
            && !o_controller_enable && o_string_enable == '0)
        else $error("power down left outputs on");
    a_ov_blocks:
        assert property (i_output_overvoltage_sense [*3] |=>
            !o_boost_switch_enable) else $error("boost on during ov");
    a_scan_gate:
        assert property (!o_scan_done && !$past(o_scan_done) |->
            !o_boost_clock_tick && !o_boost_switch_enable)
        else $error("boost active before scan end");
    a_mask_frozen:
        assert property (o_controller_enable && $past(o_controller_enable)
            |-> $stable(o_string_mask)) else $error("mask changed");
    a_strings_masked:
        assert property ((o_string_enable & ~$past(o_string_mask)) == '0)
        else $error("unused string enabled");
    a_fault_reg_on:
        assert property ($rose(o_fault_latched) |-> o_regulator_enable)
        else $error("fault stopped regulator");
    a_fault_all_off:
        assert property (o_fault_latched && $past(o_fault_latched) |->
            !o_controller_enable && !o_boost_switch_enable
            && o_string_enable == '0) else $error("fault left drive on");
    a_conv_off:
        assert property (!i_converter_on_time [*3] |=> o_string_enable == '0)
        else $error("strings on in off-time");
endmodule : led_ctl_assertions
bind led_string_driver_control led_ctl_assertions i_chk (.*);

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import led_driver_pkg::*;
    logic       clk = 0, rst = 1, pd_n = 0, vcc = 0, flo = 0, fhi = 0;
    logic       ovs = 0, mode = 0, conv = 1, pwm, sdone, ctl, tick, fault;
    logic       bst, ren, lck;
    logic [5:0] gnd = 6'h05, over = 6'h00, mask, sen;
    logic [8:0] duty;
    logic [7:0] amp, hi, lo;
    logic [47:0] lvl = 48'h10_20_30_05_50_70;
    int         miscompares = 0, tests_run = 0, n, cyc = 0;
    always #4 clk = ~clk;
    host_brightness_model i_host (.i_clk(clk), .o_pwm(pwm));
    led_string_driver_control #(.SCAN_CYCLES_P(20), .FAULT_CYCLES_P(100))
    i_dut (.i_clk(clk), .i_rst(rst), .i_power_down_input_n(pd_n),
        .i_vcc_above_rise(vcc), .i_vcc_above_fall(vcc),
        .i_freq_sel_above_low(flo), .i_freq_sel_above_high(fhi),
        .i_output_overvoltage_sense(ovs), .i_brightness_pwm_input(pwm),
        .i_dimming_mode_select(mode), .i_converter_on_time(conv),
        .i_string_feedback_grounded(gnd), .i_string_feedback_over(over),
        .i_string_feedback_level(lvl), .i_loop_free_run_period(22'h002710),
        .o_regulator_enable(), .o_reference_enable(ren), .o_string_enable(sen),
        .o_controller_enable(ctl), .o_scan_done(sdone), .o_string_mask(mask),
        .o_current_amplitude(amp), .o_boost_switch_enable(bst),
        .o_boost_clock_tick(tick), .o_highest_string_level(hi),
        .o_lowest_string_level(lo), .o_brightness_duty(duty),
        .o_fault_latched(fault), .o_loop_locked(lck));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic tick_gap(input logic lo, input logic hi, input int exp);
        flo <= lo;
        fhi <= hi;
        repeat (10) @(posedge clk);
        for (n = 0; n < 300 && !tick; n++) @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 300 && !tick; n++) @(posedge clk);
        check(n, exp);
    endtask : tick_gap
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        vcc <= 1;
        pd_n <= 1;
        for (n = 0; n < 60 && !sdone; n++) @(posedge clk);
        check(n, 25);
        check(mask, 6'h3a);
        gnd <= 6'h3f;
        repeat (8) @(posedge clk);
        check(mask, 6'h3a);
        check({hi, lo}, 16'h5010);
        tick_gap(0, 0, 250);
        tick_gap(1, 0, 166);
        tick_gap(1, 1, 125);
        ovs <= 1;
        repeat (5) @(posedge clk);
        check(bst, 0);
        ovs <= 0;
        conv <= 0;
        repeat (5) @(posedge clk);
        check({bst, sen}, 7'h40);
        conv <= 1;
        repeat (5) @(posedge clk);
        check(sen, 6'h3a);
        // two rises needed, one clean period between them: the first rise measures nothing useful
        repeat (30000) @(posedge clk);
        check(duty, 9'h083);
        check(lck, 1);
        mode <= 1;
        repeat (13000) @(posedge clk);
        check(amp, 8'h83);
        mode <= 0;
        repeat (5) @(posedge clk);
        check(amp, 8'hff);
        over <= 6'h02;
        repeat (150) @(posedge clk);
        over <= 6'h00;
        repeat (4) @(posedge clk);
        check(fault, 0);
        over <= 6'h02;
        for (n = 0; n < 400 && !fault; n++) @(posedge clk);
        check(n >= 190 && n <= 205, 1);
        over <= 6'h00;
        repeat (10) @(posedge clk);
        check(fault, 1);
        pd_n <= 0;
        repeat (5) @(posedge clk);
        check(fault, 0);
        check(ren, 0);
        pd_n <= 1;
        for (n = 0; n < 60 && !sdone; n++) @(posedge clk);
        check(ctl, 1);
        vcc <= 0;
        repeat (5) @(posedge clk);
        check(ctl, 0);
        report_and_stop();
    end
endmodule : testbench
